/* File: dacr_pkg.sv */
// register layout, reset values and field types of the converter configuration bank
// assumes a byte-wide register port with page and offset supplied by the device's control port
package dacr_pkg;

  // ************************************************
  // register offsets
  // ************************************************
  localparam logic [7:0] PAGE_STATUS        = 8'h00;
  localparam logic [7:0] PAGE_CONFIG        = 8'h01;
  localparam logic [7:0] OFS_AUTO_MUTE      = 8'h78;  // page 0
  localparam logic [7:0] OFS_CORE_MODE      = 8'h79;  // page 0
  localparam logic [7:0] OFS_REF_OUT_SEL    = 8'h01;  // page 1
  localparam logic [7:0] OFS_GAIN_SEL       = 8'h02;  // page 1
  localparam logic [7:0] OFS_PUMP_DELAY     = 8'h03;  // page 1
  localparam logic [7:0] OFS_DRIVER_POWER   = 8'h04;  // page 1

  // ************************************************
  // field positions
  // ************************************************
  localparam int BIT_LEFT_MUTE      = 4;
  localparam int BIT_RIGHT_MUTE     = 0;
  localparam int BIT_ROT_DISABLE    = 4;
  localparam int BIT_MODE_LO        = 0;
  localparam int BIT_REF_SRC        = 4;
  localparam int BIT_AMP_TYPE       = 0;
  localparam int BIT_LEFT_GAIN      = 4;
  localparam int BIT_RIGHT_GAIN     = 0;
  localparam int BIT_DELAY_LO       = 0;
  localparam int BIT_POWER_LO       = 0;

  // ************************************************
  // reset values
  // ************************************************
  localparam logic       RST_ROT_DISABLE = 1'h0;
  localparam logic [1:0] RST_MODE        = 2'h0;
  localparam logic       RST_REF_SRC     = 1'h0;
  localparam logic       RST_AMP_TYPE    = 1'h0;
  localparam logic       RST_GAIN        = 1'h0;
  localparam logic [2:0] RST_DELAY       = 3'h0;
  localparam logic [1:0] RST_POWER       = 2'h1;

  // ************************************************
  // pump clock delay in ns, per code
  // ************************************************
  localparam int PUMP_DELAY_BASE_NS = 65;
  localparam int PUMP_DELAY_STEP_NS = 25;

  // converter core modes
  typedef enum logic [1:0] {
    DACR_CASC_GALTON   = 2'h0,
    DACR_CASC_ROTATE   = 2'h1,
    DACR_PLAIN_GALTON  = 2'h2,
    DACR_PLAIN_ROTATE  = 2'h3
  } dacr_mode_t;

  // configuration carried to the analog core
  typedef struct packed {
    logic       rotation_disable;
    dacr_mode_t converter_mode_select;
    logic       reference_source_select;
    logic       amplitude_type_select;
    logic       left_analog_gain;
    logic       right_analog_gain;
    logic [2:0] pump_clock_delay;
    logic [1:0] driver_power_level;
  } dacr_cfg_t;

endpackage

/* File: dacr_regs.sv */
// configuration and auto-mute status register bank of the audio converter core
// assumes the control port hands over page, offset and one-cycle read/write strobes
//
// Function
// - left auto-mute flag reads at bit 4, one while left channel muted.
// - right auto-mute flag reads at bit 0, one while right channel muted.
// - bit 4 rotation disable, reset 0; one stops weighted-averaging rotation.
// - mode bits 1:0, reset 0: cascaded Galton/rotation, non-cascaded Galton/rotation.
// - bit 4 reference source, reset 0: divided supply or bandgap on common pin.
// - bit 0 amplitude type, reset 0: constant, or proportional to analog supply.
// - left gain bit 4, reset 0: 0 dB or -6 dB.
// - right gain bit 0, reset 0: 0 dB or -6 dB.
// - pump delay bits 2:0, reset 0: 65 ns plus 25 ns per step.
// - driver power bits 1:0, reset 1: normal, increased, more, maximum.
`timescale 1ns/100ps
module dacr_regs (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // register port
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_page,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_rvalid,
  // auto-mute levels from the signal path
  input  wire logic                left_muted_in,
  input  wire logic                right_muted_in,
  // configuration to the analog core
  output dacr_pkg::dacr_cfg_t      cfg,
  output logic                     core_cascaded,
  output logic                     core_rotating,
  output logic [7:0]               pump_delay_ns,
  output logic                     autoset_blocked
);

  // ************************************************
  // address decode
  // ************************************************
  logic [1:0] mute_sync;
  logic       hit_mode;
  logic       hit_ref;
  logic       hit_gain;
  logic       hit_delay;
  logic       hit_power;
  logic       hit_mute;

  // field registers, each written by exactly one process and gathered into cfg below
  logic                 rot_disable_reg;
  dacr_pkg::dacr_mode_t mode_reg;
  logic                 ref_src_reg;
  logic                 amp_type_reg;
  logic                 left_gain_reg;
  logic                 right_gain_reg;
  logic [2:0]           delay_reg;
  logic [1:0]           power_reg;

  assign hit_mute  = (reg_page == dacr_pkg::PAGE_STATUS) && (reg_addr == dacr_pkg::OFS_AUTO_MUTE);
  assign hit_mode  = (reg_page == dacr_pkg::PAGE_STATUS) && (reg_addr == dacr_pkg::OFS_CORE_MODE);
  assign hit_ref   = (reg_page == dacr_pkg::PAGE_CONFIG) && (reg_addr == dacr_pkg::OFS_REF_OUT_SEL);
  assign hit_gain  = (reg_page == dacr_pkg::PAGE_CONFIG) && (reg_addr == dacr_pkg::OFS_GAIN_SEL);
  assign hit_delay = (reg_page == dacr_pkg::PAGE_CONFIG) && (reg_addr == dacr_pkg::OFS_PUMP_DELAY);
  assign hit_power = (reg_page == dacr_pkg::PAGE_CONFIG) && (reg_addr == dacr_pkg::OFS_DRIVER_POWER);

  // mute flags come from another domain, so they pass two flops first
  dacr_sync #(
    .WIDTH (2)
  ) u_mute_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({left_muted_in, right_muted_in}),
    .sync_out (mute_sync)
  );

  // ************************************************
  // writable fields
  // ************************************************
  // core mode register; reserved bits are dropped, they read back as zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rot_disable_reg <= dacr_pkg::RST_ROT_DISABLE;
      mode_reg        <= dacr_pkg::dacr_mode_t'(dacr_pkg::RST_MODE);
    end
    else if (reg_wr && hit_mode)
    begin
      rot_disable_reg <= reg_wdata[dacr_pkg::BIT_ROT_DISABLE];
      mode_reg        <=
        dacr_pkg::dacr_mode_t'(reg_wdata[dacr_pkg::BIT_MODE_LO +: 2]);
    end
  end

  // reference and amplitude type
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_src_reg  <= dacr_pkg::RST_REF_SRC;
      amp_type_reg <= dacr_pkg::RST_AMP_TYPE;
    end
    else if (reg_wr && hit_ref)
    begin
      ref_src_reg  <= reg_wdata[dacr_pkg::BIT_REF_SRC];
      amp_type_reg <= reg_wdata[dacr_pkg::BIT_AMP_TYPE];
    end
  end

  // analog gain per channel
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      left_gain_reg  <= dacr_pkg::RST_GAIN;
      right_gain_reg <= dacr_pkg::RST_GAIN;
    end
    else if (reg_wr && hit_gain)
    begin
      left_gain_reg  <= reg_wdata[dacr_pkg::BIT_LEFT_GAIN];
      right_gain_reg <= reg_wdata[dacr_pkg::BIT_RIGHT_GAIN];
    end
  end

  // pump clock delay and its delay in ns, kept together so they never disagree
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      delay_reg            <= dacr_pkg::RST_DELAY;
      pump_delay_ns        <= 8'(dacr_pkg::PUMP_DELAY_BASE_NS);
    end
    else if (reg_wr && hit_delay)
    begin
      delay_reg            <= reg_wdata[dacr_pkg::BIT_DELAY_LO +: 3];
      pump_delay_ns        <= 8'(dacr_pkg::PUMP_DELAY_BASE_NS
                              + dacr_pkg::PUMP_DELAY_STEP_NS
                              * int'(reg_wdata[dacr_pkg::BIT_DELAY_LO +: 3]));
    end
  end

  // output driver power
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      power_reg <= dacr_pkg::RST_POWER;
    else if (reg_wr && hit_power)
      power_reg <= reg_wdata[dacr_pkg::BIT_POWER_LO +: 2];
  end

  // single driver for the struct output; a flop-per-field split keeps each process small
  assign cfg = '{
    rotation_disable:        rot_disable_reg,
    converter_mode_select:   mode_reg,
    reference_source_select: ref_src_reg,
    amplitude_type_select:   amp_type_reg,
    left_analog_gain:        left_gain_reg,
    right_analog_gain:       right_gain_reg,
    pump_clock_delay:        delay_reg,
    driver_power_level:      power_reg
  };

  // ************************************************
  // decoded mode and autoset warning
  // ************************************************
  // odd mode codes rotate, low codes cascade; decoded from the written value
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      core_cascaded   <= 1'h1;
      core_rotating   <= 1'h0;
      autoset_blocked <= 1'h0;
    end
    else
    begin
      if (reg_wr && hit_mode)
      begin
        case (reg_wdata[dacr_pkg::BIT_MODE_LO +: 2])
          dacr_pkg::DACR_CASC_GALTON:  {core_cascaded, core_rotating} <= 2'h2;
          dacr_pkg::DACR_CASC_ROTATE:  {core_cascaded, core_rotating} <= 2'h3;
          dacr_pkg::DACR_PLAIN_GALTON: {core_cascaded, core_rotating} <= 2'h0;
          default:                     {core_cascaded, core_rotating} <= 2'h1;
        endcase
      end
      // flags that clock autoset cannot run; software must program dividers
      if (reg_wr && hit_ref)
        autoset_blocked <= reg_wdata[dacr_pkg::BIT_AMP_TYPE];
    end
  end

  // ************************************************
  // read path
  // ************************************************
  // one cycle latency; unmapped offsets and reserved bits read zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'h0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata <= 8'h00;
        if (hit_mute)
        begin
          reg_rdata[dacr_pkg::BIT_LEFT_MUTE]  <= mute_sync[1];
          reg_rdata[dacr_pkg::BIT_RIGHT_MUTE] <= mute_sync[0];
        end
        else if (hit_mode)
        begin
          reg_rdata[dacr_pkg::BIT_ROT_DISABLE]    <= cfg.rotation_disable;
          reg_rdata[dacr_pkg::BIT_MODE_LO +: 2]   <= cfg.converter_mode_select;
        end
        else if (hit_ref)
        begin
          reg_rdata[dacr_pkg::BIT_REF_SRC]  <= cfg.reference_source_select;
          reg_rdata[dacr_pkg::BIT_AMP_TYPE] <= cfg.amplitude_type_select;
        end
        else if (hit_gain)
        begin
          reg_rdata[dacr_pkg::BIT_LEFT_GAIN]  <= cfg.left_analog_gain;
          reg_rdata[dacr_pkg::BIT_RIGHT_GAIN] <= cfg.right_analog_gain;
        end
        else if (hit_delay)
          reg_rdata[dacr_pkg::BIT_DELAY_LO +: 3] <= cfg.pump_clock_delay;
        else if (hit_power)
          reg_rdata[dacr_pkg::BIT_POWER_LO +: 2] <= cfg.driver_power_level;
      end
    end
  end

endmodule

/* File: dacr_regs_monitor.sv */
// port assertions for the converter configuration register bank
// assumes it is bound to every dacr_regs instance and sees only its ports
`timescale 1ns/100ps
module dacr_regs_monitor (
  // clock and reset
  input wire logic                clk,
  input wire logic                rst_b,
  // register port
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_page,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic [7:0]          reg_rdata,
  input wire logic                reg_rvalid,
  // mute levels and core outputs
  input wire logic                left_muted_in,
  input wire logic                right_muted_in,
  input wire dacr_pkg::dacr_cfg_t cfg,
  input wire logic                core_cascaded,
  input wire logic                core_rotating,
  input wire logic [7:0]          pump_delay_ns,
  input wire logic                autoset_blocked
);
  // ************************************************
  // decoded strobes
  // ************************************************
  logic wr0;
  logic wr1;
  // page decode kept outside the properties so each stays short
  assign wr0 = reg_wr && reg_page == 8'h00;
  assign wr1 = reg_wr && reg_page == 8'h01;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ************************************************
  // assertions
  // ************************************************
  read_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  read_single_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("stray read answer");
  status_spare_a: assert property (reg_rd && reg_page == 8'h00 && reg_addr == 8'h78
    |=> (reg_rdata & 8'hEE) == 8'h00) else $error("status spare bits set");
  // flags pass two sync flops and the read register, so data lags the pins by three edges
  mute_read_a: assert property (reg_rd && reg_page == 8'h00 && reg_addr == 8'h78
    |=> reg_rdata[4] == $past(left_muted_in, 3) && reg_rdata[0] == $past(right_muted_in, 3))
    else $error("mute flags wrong");
  mode_write_a: assert property (wr0 && reg_addr == 8'h79
    |=> {3'h0, cfg.rotation_disable, 2'h0, cfg.converter_mode_select}
    == ($past(reg_wdata) & 8'h13)) else $error("mode write lost");
  mode_decode_a: assert property (core_cascaded == !cfg.converter_mode_select[1]
    && core_rotating == cfg.converter_mode_select[0]) else $error("mode decode wrong");
  ref_write_a: assert property (wr1 && reg_addr == 8'h01
    |=> {3'h0, cfg.reference_source_select, 3'h0, cfg.amplitude_type_select}
    == ($past(reg_wdata) & 8'h11)) else $error("ref write lost");
  autoset_flag_a: assert property (autoset_blocked == cfg.amplitude_type_select)
    else $error("autoset flag wrong");
  gain_write_a: assert property (wr1 && reg_addr == 8'h02
    |=> {3'h0, cfg.left_analog_gain, 3'h0, cfg.right_analog_gain}
    == ($past(reg_wdata) & 8'h11)) else $error("gain write lost");
  delay_ns_a: assert property (
    pump_delay_ns == 8'h41 + 8'h19 * {5'h00, cfg.pump_clock_delay})
    else $error("pump delay wrong");
  power_write_a: assert property (wr1 && reg_addr == 8'h04
    |=> {6'h00, cfg.driver_power_level} == ($past(reg_wdata) & 8'h03))
    else $error("power write lost");
  cfg_hold_a: assert property (!reg_wr |=> $stable(cfg)) else $error("cfg moved");

  // main scenarios reached
  cover property (wr1 && reg_addr == 8'h04);
  cover property (reg_rvalid && reg_rdata[4]);
  cover property (core_rotating && !core_cascaded);
endmodule

bind dacr_regs dacr_regs_monitor u_dacr_regs_monitor (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .left_muted_in(left_muted_in),
  .right_muted_in(right_muted_in), .cfg(cfg), .core_cascaded(core_cascaded),
  .core_rotating(core_rotating), .pump_delay_ns(pump_delay_ns), .autoset_blocked(autoset_blocked));

/* File: dacr_regs_tb.sv */
// self-checking bench for the converter configuration register bank
// assumes dacr_regs_monitor is bound from its own file
`timescale 1ns/100ps
module dacr_regs_tb;
  // ************************************************
  // signals and expected register image
  // ************************************************
  logic                clk;
  logic                rst_b;
  logic                reg_wr, reg_rd, reg_rvalid, left_muted_in, right_muted_in;
  logic [7:0]          reg_page, reg_addr, reg_wdata, reg_rdata, pump_delay_ns;
  logic                core_cascaded, core_rotating, autoset_blocked;
  dacr_pkg::dacr_cfg_t cfg;
  logic [7:0]          shadow [2][256];
  int                  n_mismatch, checks_done;

  dacr_regs u_dacr_regs (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .left_muted_in(left_muted_in), .right_muted_in(right_muted_in),
    .cfg(cfg), .core_cascaded(core_cascaded), .core_rotating(core_rotating),
    .pump_delay_ns(pump_delay_ns), .autoset_blocked(autoset_blocked));

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // writable bits; reserved and unmapped places read zero
  function automatic logic [7:0] wmask(logic [7:0] p, logic [7:0] a);
    if (p == 8'h00)
      return (a == 8'h79) ? 8'h13 : 8'h00;
    if (p != 8'h01)
      return 8'h00;
    case (a)
      8'h01, 8'h02: return 8'h11;
      8'h03: return 8'h07;
      8'h04: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] exp_rd(logic [7:0] p, logic [7:0] a);
    if (p == 8'h00 && a == 8'h78)
      return {3'h0, left_muted_in, 3'h0, right_muted_in};
    return shadow[p[0]][a] & wmask(p, a);
  endfunction

  function automatic logic [15:0] exp_cfg();
    return 16'({shadow[0][8'h79][4], shadow[0][8'h79][1:0], shadow[1][8'h01][4],
      shadow[1][8'h01][0], shadow[1][8'h02][4], shadow[1][8'h02][0], shadow[1][8'h03][2:0],
      shadow[1][8'h04][1:0]});
  endfunction

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // core outputs against the image, checked after every write
  task automatic check_core();
    check("cfg", 16'(cfg), exp_cfg());
    check("cascaded", 16'(core_cascaded), 16'(!shadow[0][8'h79][1]));
    check("rotating", 16'(core_rotating), 16'(shadow[0][8'h79][0]));
    check("delay_ns", 16'(pump_delay_ns), 16'(8'h41 + 8'h19 * shadow[1][8'h03][2:0]));
    check("autoset", 16'(autoset_blocked), 16'(shadow[1][8'h01][0]));
  endtask

  // each access waits an edge first, so a strobe is never lowered and raised in one step
  task automatic wr(logic [7:0] p, logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_page = p;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    if (p < 8'h02)
      shadow[p[0]][a] = d;
    check_core();
  endtask

  task automatic rd(logic [7:0] p, logic [7:0] a);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_page = p;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    check("rvalid", 16'(reg_rvalid), 16'h0001);
    check("rdata", 16'(reg_rdata), 16'(exp_rd(p, a)));
  endtask

  task automatic stop_test();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ************************************************
  // main sequence: two passes, the second after a mid-run reset
  // ************************************************
  initial
  begin
    logic [7:0] pl [5];
    logic [7:0] al [5];
    pl = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h01};
    al = '{8'h79, 8'h01, 8'h02, 8'h03, 8'h04};
    void'($urandom(32'hc06f684b));
    {reg_wr, reg_rd, left_muted_in, right_muted_in} = 4'h0;
    {reg_page, reg_addr, reg_wdata} = 24'h000000;
    for (int r = 0; r < 2; r++)
    begin
      rst_b = 1'b0;
      foreach (shadow[i, j])
        shadow[i][j] = 8'h00;
      shadow[1][8'h04] = 8'h01;
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      check_core();
      for (int k = 0; k < 5; k++)
        rd(pl[k], al[k]);
      // low bits walk every code; upper bits random, reserved ones must be dropped
      for (int i = 0; i < 8; i++)
      begin
        left_muted_in = 1'($urandom);
        right_muted_in = 1'($urandom);
        for (int k = 0; k < 5; k++)
        begin
          wr(pl[k], al[k], (8'($urandom) & 8'hF8) | 8'(i));
          rd(pl[k], al[k]);
        end
        wr(8'h00, 8'h78, 8'hFF);
        wr(8'($urandom % 4), 8'($urandom), 8'($urandom));
        rd(8'($urandom % 4), 8'($urandom));
        rd(8'h00, 8'h78);
      end
    end
    stop_test();
  end

  // the sequence needs about 500 cycles
  initial
  begin
    #80000;
    n_mismatch++;
    stop_test();
  end
endmodule

/* File: dacr_sync.sv */
// two-flop synchroniser for level signals that arrive from outside the clock domain
// assumes inputs are slow levels; pulses shorter than one clock may be missed
`timescale 1ns/100ps
module dacr_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule
